// *** fmsp_regs.svh ***
// Purpose: register offsets, field positions, reset values, timing counts
// Assumes: byte-wide special register port
// Notes:   definitions only
`ifndef FMSP_REGS_SVH
`define FMSP_REGS_SVH

// register offsets
`define FMSP_ADDR_SERCTL  8'h10
`define FMSP_ADDR_SERBUF  8'h11
`define FMSP_ADDR_AUXTMR  8'h12
`define FMSP_ADDR_RATECTL 8'h13

// serial_control field positions
`define FMSP_SC_MODEHI    7
`define FMSP_SC_MODELO    6
`define FMSP_SC_MPEN      5
`define FMSP_SC_RXEN      4
`define FMSP_SC_TXNINTH   3
`define FMSP_SC_RXNINTH   2
`define FMSP_SC_TXDONE    1
`define FMSP_SC_RXDONE    0

// aux_timer_control field positions
`define FMSP_AT_RXSRC     5
`define FMSP_AT_TXSRC     4

// rate control field position
`define FMSP_RC_FAST      0

// reset values
`define FMSP_SERCTL_RST   8'h00
`define FMSP_AUXTMR_RST   8'h00
`define FMSP_FAST_RST     1'b0

// timing counts
`define FMSP_M0_LAST      4'hb
`define FMSP_M0_HALF      4'h6
`define FMSP_M0_SAMPLE    4'h5
`define FMSP_OVS_LAST     4'hf
`define FMSP_OVS_MID      4'h7
`define FMSP_PRE_FAST     2'h1
`define FMSP_PRE_SLOW     2'h3
`define FMSP_BITS_M1      4'h9
`define FMSP_BITS_M23     4'ha

`endif

// *** fmsp_pkg.sv ***
// Purpose: shared types of the serial port
// Assumes: constants live in fmsp_regs.svh
// Notes:   none
package fmsp_pkg;

  typedef enum logic [1:0] {
    FMSP_MODE_SHIFT,
    FMSP_MODE_ASYNC8,
    FMSP_MODE_ASYNC9_FIXED,
    FMSP_MODE_ASYNC9_VAR
  } fmsp_mode_type;

  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT0, TX_FRAME} fmsp_tx_state_type;

  typedef enum logic [1:0] {RX_IDLE, RX_SHIFT0, RX_START, RX_DATA} fmsp_rx_state_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] data;
  } fmsp_sfr_req_type;

endpackage

// *** fmsp_rx_holding.sv ***
// Purpose: receive holding register, separate from the transmit shifter
// Assumes: one byte deep
// Notes:   read data comes from a register
`timescale 1ns/100ps
module fmsp_rx_holding
  import fmsp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       wrEn,
  input  wire logic [7:0] wrData,
  output logic [7:0]      rdData
);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= 8'h00;
    end else if (wrEn) begin
      rdData <= wrData;
    end
  end

endmodule

// *** fmsp_baud_gen.sv ***
// Purpose: 16x oversample enables for transmitter and receiver
// Assumes: timer overflow inputs are one-cycle pulses
// Notes:   mode 0 timing is kept by the main block
`timescale 1ns/100ps
`include "fmsp_regs.svh"
module fmsp_baud_gen
  import fmsp_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire fmsp_mode_type mode,
  input  wire logic          fastRate,
  input  wire logic          txSrcT2,
  input  wire logic          rxSrcT2,
  input  wire logic          t1Ovf,
  input  wire logic          t2Ovf,
  output logic               txTick,
  output logic               rxTick
);

  logic [1:0] preQ;
  logic       preHit;

  assign preHit = (preQ == (fastRate ? `FMSP_PRE_FAST : `FMSP_PRE_SLOW));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      preQ <= 2'h0;
    end else if (preHit) begin
      preQ <= 2'h0;
    end else begin
      preQ <= preQ + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txTick <= 1'b0;
      rxTick <= 1'b0;
    end else begin
      case (mode)
        FMSP_MODE_ASYNC9_FIXED: begin
          txTick <= preHit;
          rxTick <= preHit;
        end
        FMSP_MODE_ASYNC8, FMSP_MODE_ASYNC9_VAR: begin
          txTick <= txSrcT2 ? t2Ovf : t1Ovf;
          rxTick <= rxSrcT2 ? t2Ovf : t1Ovf;
        end
        default: begin
          txTick <= 1'b0;
          rxTick <= 1'b0;
        end
      endcase
    end
  end

  property p_tx_src;
    @(posedge clk) disable iff (!rst_n)
      ((mode == FMSP_MODE_ASYNC8 || mode == FMSP_MODE_ASYNC9_VAR) && txSrcT2 && t2Ovf)
        |=> txTick;
  endproperty
  a_tx_src: assert property (p_tx_src) else $error("tx tick missed timer 2 overflow");

  property p_rx_src;
    @(posedge clk) disable iff (!rst_n)
      (mode == FMSP_MODE_ASYNC8 && !rxSrcT2 && !t1Ovf) |=> !rxTick;
  endproperty
  a_rx_src: assert property (p_rx_src) else $error("rx tick without timer 1 overflow");

  property p_slow_rate;
    @(posedge clk) disable iff (!rst_n)
      (txTick && mode == FMSP_MODE_ASYNC9_FIXED && !fastRate)
        |=> (!txTick || mode != FMSP_MODE_ASYNC9_FIXED)
        ##1 (!txTick || mode != FMSP_MODE_ASYNC9_FIXED || fastRate)
        ##1 (!txTick || mode != FMSP_MODE_ASYNC9_FIXED);
  endproperty
  a_slow_rate: assert property (p_slow_rate) else $error("slow rate tick too early");

endmodule

// *** fmsp_serial_port.sv ***
// Purpose: four-mode full-duplex serial port with receive buffering
// Assumes: byte-wide register port, timer overflow pulses from outside
// Notes:   one clock, 20 MHz
// How it works
// - tx clocked by timer 2 when selected
// - rx clocked by timer 2 when selected
// - timer 2 baud role when either select set
// - async transmitter and receiver run independently
// - new byte received while old unread
// - one address, write tx, read rx
// - mode 0 data on rxd, clock on txd
// - mode 1 frame start, 8 data, stop
// - mode 1 stop bit into received ninth
// - modes 2/3 frame with ninth bit
// - modes 2/3 store ninth, ignore stop
// - mode 2 rate osc/32 or osc/64
// - mode 3 equals mode 2, timer rate
// - buffer write starts a transmission
// - mode 0 rx starts on done clear, enabled
// - async rx starts on start bit, enabled
// - filter passes only ninth bit set
// - filter ignored in mode 0
// - mode 1 filter needs valid stop
`timescale 1ns/100ps
`include "fmsp_regs.svh"
module fmsp_serial_port
  import fmsp_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire fmsp_sfr_req_type sfrReq,
  output logic [7:0]            sfrRdata,
  input  wire logic             t1Ovf,
  input  wire logic             t2Ovf,
  output logic                  baudGenMode,
  input  wire logic             rxdIn,
  output logic                  rxdOut,
  output logic                  rxdOe,
  output logic                  txdOut
);

  ////////////////////////////////////////////////////////////////////
  fmsp_mode_type     mode_q;
  fmsp_tx_state_type txState_q;
  fmsp_rx_state_type rxState_q;
  logic        mpEn_q, rxEn_q, txNinth_q, rxNinth_q, txDone_q, rxDone_q;
  logic [7:0]  auxTmr_q;
  logic        fast_q;
  logic        txTick, rxTick;
  logic [7:0]  rxHold;
  logic [3:0]  ph_q;
  logic [10:0] txSh_q;
  logic [3:0]  txBit_q, txSub_q;
  logic [9:0]  rxSh_q;
  logic [9:0]  rxShNext;
  logic [3:0]  rxBit_q, rxSub_q;
  logic [3:0]  rxNeed;
  logic        txSetDone, rxAccept, rxLast, rxDataSample;
  logic        rxNinthIn, rxStopIn;
  logic [7:0]  rxByteIn;
  logic        wrCtl, wrBuf, wrAux, wrRate, m0Start, m0Edge;

  function automatic logic hit(input fmsp_sfr_req_type r, input logic [7:0] a);
    hit = r.wr && (r.addr == a);
  endfunction

  assign wrCtl  = hit(sfrReq, `FMSP_ADDR_SERCTL);
  assign wrBuf  = hit(sfrReq, `FMSP_ADDR_SERBUF);
  assign wrAux  = hit(sfrReq, `FMSP_ADDR_AUXTMR);
  assign wrRate = hit(sfrReq, `FMSP_ADDR_RATECTL);

  ////////////////////////////////////////////////////////////////////
  fmsp_baud_gen u_baud (
    .clk      (clk),
    .rst_n    (rst_n),
    .mode     (mode_q),
    .fastRate (fast_q),
    .txSrcT2  (auxTmr_q[`FMSP_AT_TXSRC]),
    .rxSrcT2  (auxTmr_q[`FMSP_AT_RXSRC]),
    .t1Ovf    (t1Ovf),
    .t2Ovf    (t2Ovf),
    .txTick   (txTick),
    .rxTick   (rxTick)
  );

  fmsp_rx_holding u_hold (
    .clk    (clk),
    .rst_n  (rst_n),
    .wrEn   (rxAccept),
    .wrData (rxByteIn),
    .rdData (rxHold)
  );

  ////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q    <= FMSP_MODE_SHIFT;
      mpEn_q    <= 1'(`FMSP_SERCTL_RST >> `FMSP_SC_MPEN);
      rxEn_q    <= 1'b0;
      txNinth_q <= 1'b0;
    end else if (wrCtl) begin
      mode_q    <= fmsp_mode_type'({sfrReq.data[`FMSP_SC_MODEHI],
                                    sfrReq.data[`FMSP_SC_MODELO]});
      mpEn_q    <= sfrReq.data[`FMSP_SC_MPEN];
      rxEn_q    <= sfrReq.data[`FMSP_SC_RXEN];
      txNinth_q <= sfrReq.data[`FMSP_SC_TXNINTH];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      auxTmr_q    <= `FMSP_AUXTMR_RST;
      fast_q      <= `FMSP_FAST_RST;
      baudGenMode <= 1'b0;
    end else begin
      if (wrAux) begin
        auxTmr_q <= sfrReq.data;
      end
      if (wrRate) begin
        fast_q <= sfrReq.data[`FMSP_RC_FAST];
      end
      baudGenMode <= auxTmr_q[`FMSP_AT_RXSRC] | auxTmr_q[`FMSP_AT_TXSRC];
    end
  end

  // sticky flags: hardware set wins over a software write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txDone_q  <= 1'b0;
      rxDone_q  <= 1'b0;
      rxNinth_q <= 1'b0;
    end else begin
      if (txSetDone) begin
        txDone_q <= 1'b1;
      end else if (wrCtl) begin
        txDone_q <= sfrReq.data[`FMSP_SC_TXDONE];
      end
      if (rxAccept) begin
        rxDone_q  <= 1'b1;
        rxNinth_q <= rxNinthIn;
      end else if (wrCtl) begin
        rxDone_q  <= sfrReq.data[`FMSP_SC_RXDONE];
        rxNinth_q <= sfrReq.data[`FMSP_SC_RXNINTH];
      end
    end
  end

  // read port: one address, two physical registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sfrRdata <= 8'h00;
    end else if (sfrReq.rd) begin
      case (sfrReq.addr)
        `FMSP_ADDR_SERCTL:  sfrRdata <= {mode_q, mpEn_q, rxEn_q, txNinth_q,
                                         rxNinth_q, txDone_q, rxDone_q};
        `FMSP_ADDR_SERBUF:  sfrRdata <= rxHold;
        `FMSP_ADDR_AUXTMR:  sfrRdata <= auxTmr_q;
        `FMSP_ADDR_RATECTL: sfrRdata <= {7'h00, fast_q};
        default:            sfrRdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // mode 0 bit timer, osc/12, restarted by each shift start
  assign m0Start = (mode_q == FMSP_MODE_SHIFT) &&
                   (wrBuf || (rxState_q == RX_IDLE && txState_q == TX_IDLE &&
                              rxEn_q && !rxDone_q));
  assign m0Edge  = (ph_q == `FMSP_M0_LAST);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_q <= 4'h0;
    end else if (m0Start || m0Edge) begin
      ph_q <= 4'h0;
    end else begin
      ph_q <= ph_q + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // transmitter
  assign txSetDone = ((txState_q == TX_SHIFT0) && m0Edge && txBit_q == 4'h7) ||
                     ((txState_q == TX_FRAME) && txTick && txSub_q == `FMSP_OVS_LAST &&
                      txBit_q == ((mode_q == FMSP_MODE_ASYNC8) ?
                                  `FMSP_BITS_M1 - 4'h1 : `FMSP_BITS_M23 - 4'h1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txState_q <= TX_IDLE;
      txSh_q    <= 11'h7ff;
      txBit_q   <= 4'h0;
      txSub_q   <= 4'h0;
    end else if (wrBuf) begin
      txBit_q <= 4'h0;
      txSub_q <= 4'h0;
      if (mode_q == FMSP_MODE_SHIFT) begin
        txState_q <= TX_SHIFT0;
        txSh_q    <= {3'h7, sfrReq.data};
      end else begin
        txState_q <= TX_FRAME;
        txSh_q    <= {1'b1, (mode_q == FMSP_MODE_ASYNC8) ? 1'b1 : txNinth_q,
                      sfrReq.data, 1'b0};
      end
    end else begin
      case (txState_q)
        TX_SHIFT0: begin
          if (m0Edge) begin
            txSh_q  <= {1'b1, txSh_q[10:1]};
            txBit_q <= txBit_q + 4'h1;
            if (txBit_q == 4'h7) begin
              txState_q <= TX_IDLE;
            end
          end
        end
        TX_FRAME: begin
          if (txTick) begin
            txSub_q <= txSub_q + 4'h1;
            if (txSub_q == `FMSP_OVS_LAST) begin
              txSh_q  <= {1'b1, txSh_q[10:1]};
              txBit_q <= txBit_q + 4'h1;
              if (txBit_q == ((mode_q == FMSP_MODE_ASYNC8) ?
                              `FMSP_BITS_M1 : `FMSP_BITS_M23)) begin
                txState_q <= TX_IDLE;
              end
            end
          end
        end
        default: txState_q <= TX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // receiver, separate state from the transmitter
  assign rxNeed       = (mode_q == FMSP_MODE_ASYNC8) ? `FMSP_BITS_M1 : `FMSP_BITS_M23;
  assign rxDataSample = (rxState_q == RX_DATA) && rxTick && rxSub_q == `FMSP_OVS_LAST;
  assign rxShNext     = {rxdIn, rxSh_q[9:1]};
  assign rxLast       = rxDataSample && (rxBit_q == rxNeed - 4'h1);
  assign rxStopIn     = rxShNext[9];

  always_comb begin
    if (mode_q == FMSP_MODE_SHIFT) begin
      // all eight mode 0 samples are already in the shifter at the last edge
      rxByteIn  = rxSh_q[9:2];
      rxNinthIn = rxNinth_q;
    end else if (mode_q == FMSP_MODE_ASYNC8) begin
      rxByteIn  = rxShNext[8:1];
      rxNinthIn = rxStopIn;
    end else begin
      rxByteIn  = rxShNext[7:0];
      rxNinthIn = rxShNext[8];
    end
  end

  // an unread byte blocks the new one, which is then lost
  always_comb begin
    if (rxState_q == RX_SHIFT0) begin
      rxAccept = m0Edge && rxBit_q == 4'h7;
    end else if (!rxLast || rxDone_q) begin
      rxAccept = 1'b0;
    end else if (mode_q == FMSP_MODE_ASYNC8) begin
      rxAccept = !mpEn_q || rxStopIn;
    end else begin
      rxAccept = !mpEn_q || rxShNext[8];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxState_q <= RX_IDLE;
      rxSh_q    <= 10'h000;
      rxBit_q   <= 4'h0;
      rxSub_q   <= 4'h0;
    end else begin
      case (rxState_q)
        RX_IDLE: begin
          rxBit_q <= 4'h0;
          rxSub_q <= 4'h0;
          if (m0Start && !wrBuf) begin
            rxState_q <= RX_SHIFT0;
          end else if (mode_q != FMSP_MODE_SHIFT && rxEn_q && rxTick && !rxdIn) begin
            rxState_q <= RX_START;
          end
        end
        RX_SHIFT0: begin
          if (ph_q == `FMSP_M0_SAMPLE) begin
            rxSh_q <= rxShNext;
          end
          if (m0Edge) begin
            rxBit_q <= rxBit_q + 4'h1;
            if (rxBit_q == 4'h7) begin
              rxState_q <= RX_IDLE;
            end
          end
        end
        RX_START: begin
          if (rxTick) begin
            rxSub_q <= rxSub_q + 4'h1;
            if (rxSub_q == `FMSP_OVS_MID) begin
              rxSub_q   <= 4'h0;
              rxState_q <= rxdIn ? RX_IDLE : RX_DATA; // false start rejected
            end
          end
        end
        RX_DATA: begin
          if (rxTick) begin
            rxSub_q <= rxSub_q + 4'h1;
          end
          if (rxDataSample) begin
            rxSh_q  <= rxShNext;
            rxBit_q <= rxBit_q + 4'h1;
            if (rxLast) begin
              rxState_q <= RX_IDLE;
            end
          end
        end
        default: rxState_q <= RX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txdOut <= 1'b1;
      rxdOut <= 1'b1;
      rxdOe  <= 1'b0;
    end else if (txState_q == TX_SHIFT0 || rxState_q == RX_SHIFT0) begin
      txdOut <= (ph_q >= `FMSP_M0_HALF);
      rxdOut <= txSh_q[0];
      rxdOe  <= (txState_q == TX_SHIFT0);
    end else begin
      txdOut <= (txState_q == TX_FRAME) ? txSh_q[0] : 1'b1;
      rxdOut <= 1'b1;
      rxdOe  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  sequence s_m0_write;
    wrBuf && mode_q == FMSP_MODE_SHIFT;
  endsequence

  property p_m0_clock;
    @(posedge clk) disable iff (!rst_n)
      s_m0_write ##1 !wrBuf [*3] |-> ##[1:4] !txdOut;
  endproperty
  a_m0_clock: assert property (p_m0_clock) else $error("mode 0 shift clock absent");

  property p_tx_start;
    @(posedge clk) disable iff (!rst_n)
      wrBuf |=> txState_q != TX_IDLE;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("buffer write did not start tx");

  property p_m0_rx_start;
    @(posedge clk) disable iff (!rst_n)
      (mode_q == FMSP_MODE_SHIFT && rxEn_q && !rxDone_q && !wrBuf && !wrCtl &&
       rxState_q == RX_IDLE && txState_q == TX_IDLE) |=> rxState_q == RX_SHIFT0;
  endproperty
  a_m0_rx_start: assert property (p_m0_rx_start) else $error("mode 0 rx did not start");

  property p_rx_gate;
    @(posedge clk) disable iff (!rst_n)
      (rxState_q == RX_IDLE && !rxEn_q) |=> rxState_q == RX_IDLE;
  endproperty
  a_rx_gate: assert property (p_rx_gate) else $error("rx started while disabled");

  property p_mp_filter;
    @(posedge clk) disable iff (!rst_n)
      (rxAccept && mpEn_q && mode_q[1]) |=> rxNinth_q && rxDone_q;
  endproperty
  a_mp_filter: assert property (p_mp_filter) else $error("filter passed ninth bit 0");

  property p_stop_valid;
    @(posedge clk) disable iff (!rst_n)
      (rxLast && mode_q == FMSP_MODE_ASYNC8 && mpEn_q && !rxStopIn) |-> !rxAccept;
  endproperty
  a_stop_valid: assert property (p_stop_valid) else $error("bad stop bit accepted");

  property p_overrun;
    @(posedge clk) disable iff (!rst_n)
      (rxLast && rxDone_q) |=> $stable(rxHold);
  endproperty
  a_overrun: assert property (p_overrun) else $error("unread byte overwritten");

  property p_flag_sticky;
    @(posedge clk) disable iff (!rst_n)
      (rxDone_q && !wrCtl) |=> rxDone_q;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("rx done dropped by itself");

  property p_baud_role;
    @(posedge clk) disable iff (!rst_n)
      (auxTmr_q[`FMSP_AT_TXSRC] && !wrAux) |=> ##1 baudGenMode;
  endproperty
  a_baud_role: assert property (p_baud_role) else $error("timer 2 baud role not taken");

endmodule

// *** fmsp_line_node.sv ***
// Purpose: far serial node, async frames and mode 0 shift partner
// Assumes: line idles high
// Notes:   tasks are called from the bench
`timescale 1ns/100ps
module fmsp_line_node (
  input  wire logic clk,
  input  wire logic txdOut,
  input  wire logic rxdOut,
  input  wire logic rxdOe,
  output logic      rxdDrive
);
  logic       lineQ    = 1'b1;
  logic       m0Rx     = 1'b0;
  logic [7:0] m0Tx     = 8'h00;
  logic [7:0] m0Got    = 8'h00;
  int         m0Idx    = 0;
  int         m0Per    = 0;
  realtime    lastRise = 0;

  assign rxdDrive = m0Rx ? m0Tx[m0Idx[2:0]] : lineQ;

  ////////////////////////////////////////////////////////////////
  // mode 0: data taken at clock rise, lsb first
  always @(posedge txdOut) begin
    if (rxdOe) begin
      m0Got = {rxdOut, m0Got[7:1]};
      m0Per = int'(($realtime - lastRise) / 50.0);
      lastRise = $realtime;
    end
    if (m0Rx)
      m0Idx++;
  end

  ////////////////////////////////////////////////////////////////
  // start 0, lsb first, ninth set on address bytes, stop, idle high
  task automatic send(input logic [10:0] f, input int n, input int cpb);
    for (int i = 0; i < n; i++) begin
      @(negedge clk) lineQ = f[i];
      repeat (cpb - 1) @(negedge clk);
    end
    @(negedge clk) lineQ = 1'b1;
  endtask

  task automatic recv(output logic [10:0] f, input int n, input int cpb);
    f = '1;
    @(negedge txdOut);
    repeat (cpb / 2) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      f[i] = txdOut;
      if (i < n - 1)
        repeat (cpb) @(negedge clk);
    end
  endtask
endmodule

// *** testbench.sv ***
// Purpose: self-checking bench of the serial port
// Assumes: timer 1 ticks every 2 clk, timer 2 every 4 clk
// Notes:   receive model kept in integers
`timescale 1ns/100ps
`include "fmsp_regs.svh"
module testbench
  import fmsp_pkg::*;
;
  logic             clk         = 1'b0;
  logic             rst_n       = 1'b0;
  fmsp_sfr_req_type sfrReq      = '0;
  logic             t1Ovf       = 1'b0;
  logic             t2Ovf       = 1'b0;
  logic [7:0]       sfrRdata;
  logic             baudGenMode;
  logic             rxdOut;
  logic             rxdOe;
  logic             txdOut;
  logic             rxdDrive;
  logic             rxdWire;
  logic [7:0]       lf          = 8'h47;
  int               tick        = 0;
  int               miscompares = 0;
  int               checkCount  = 0;
  int               mRi         = 0;
  int               mNinth      = 0;
  int               mBuf        = 0;

  always #25 clk = ~clk;

  always @(negedge clk) begin
    tick++;
    t1Ovf <= (tick % 2 == 0);
    t2Ovf <= (tick % 4 == 0);
  end

  assign rxdWire = rxdOe ? rxdOut : rxdDrive;

  fmsp_serial_port u_fmsp_serial_port (
    .clk(clk), .rst_n(rst_n), .sfrReq(sfrReq), .sfrRdata(sfrRdata),
    .t1Ovf(t1Ovf), .t2Ovf(t2Ovf), .baudGenMode(baudGenMode), .rxdIn(rxdWire),
    .rxdOut(rxdOut), .rxdOe(rxdOe), .txdOut(txdOut)
  );

  fmsp_line_node u_fmsp_line_node (
    .clk(clk), .txdOut(txdOut), .rxdOut(rxdOut), .rxdOe(rxdOe), .rxdDrive(rxdDrive)
  );

  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] nxt();
    lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
    return lf;
  endfunction

  task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] g);
    checkCount++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) sfrReq = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
    @(negedge clk) sfrReq = '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk) sfrReq = '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
    @(negedge clk) sfrReq = '0;
    @(negedge clk) d = sfrRdata;
  endtask

  task automatic setCtl(input logic [7:0] v);
    wr(`FMSP_ADDR_SERCTL, v);
    mRi = int'(v[0]);
    mNinth = int'(v[2]);
  endtask

  // receive model: flag, ninth bit and holding byte update together
  task automatic model(input int m, input int flt, input int b, input int n9, input int stp);
    int pass;
    pass = (m == 0) || !flt || ((m == 1) ? stp : n9);
    if (mRi == 0 && pass) begin
      mRi = 1;
      mBuf = b;
      mNinth = (m == 1) ? stp : n9;
    end
  endtask

  task automatic chkRx(input bit useNinth);
    logic [7:0] d;
    rd(`FMSP_ADDR_SERCTL, d);
    chk("rx done", 11'(mRi), 11'(d[0]));
    if (useNinth)
      chk("received ninth", 11'(mNinth), 11'(d[2]));
    rd(`FMSP_ADDR_SERBUF, d);
    chk("holding", 11'(mBuf), 11'(d));
  endtask

  task automatic waitFlag(input logic [7:0] mask);
    logic [7:0] d;
    int n;
    n = 0;
    d = 8'h00;
    while ((d & mask) == 8'h00 && n < 200) begin
      rd(`FMSP_ADDR_SERCTL, d);
      n++;
    end
    chk("flag wait", 11'(mask), 11'(d & mask));
  endtask

  task automatic conclude();
    if (miscompares == 0 && checkCount > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0]  d;
    logic [7:0]  tb;
    logic [7:0]  rb;
    logic [10:0] f;
    int          cpb;
    int          rcp;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    rd(`FMSP_ADDR_SERCTL, d);
    chk("control reset", 11'h000, 11'(d));
    rd(`FMSP_ADDR_RATECTL, d);
    chk("rate reset", 11'h000, 11'(d[0]));
    for (int i = 1; i < 5; i++) begin
      wr(`FMSP_ADDR_AUXTMR, 8'(i * 16));
      @(negedge clk);
      chk("baud role", 11'(i < 4), 11'(baudGenMode));
    end
    for (int r = 0; r < 2; r++) begin
      tb = nxt();
      cpb = r ? 32 : 64;
      wr(`FMSP_ADDR_RATECTL, 8'(r));
      setCtl({4'b1000, 1'(r), 3'b000});
      fork
        u_fmsp_line_node.recv(f, 11, cpb);
        wr(`FMSP_ADDR_SERBUF, tb);
      join
      chk("mode 2 frame", {1'b1, 1'(r), tb, 1'b0}, f);
      rd(`FMSP_ADDR_SERCTL, d);
      chk("tx done", 11'h001, 11'(d[1]));
    end
    for (int s = 0; s < 3; s++) begin
      tb = nxt();
      rb = ~tb;
      cpb = (s == 1) ? 64 : 32;
      rcp = (s == 2) ? 64 : 32;
      wr(`FMSP_ADDR_AUXTMR, 8'(s * 16));
      setCtl(8'h50);
      fork
        u_fmsp_line_node.send({1'b1, rb, 1'b0}, 10, rcp);
        u_fmsp_line_node.recv(f, 10, cpb);
        wr(`FMSP_ADDR_SERBUF, tb);
      join
      model(1, 0, rb, 0, 1);
      chk("mode 1 frame", {2'b11, tb, 1'b0}, f);
      chkRx(1);
    end
    wr(`FMSP_ADDR_AUXTMR, 8'h00);
    // mode 1 with filter on: a bad stop bit must not be accepted
    rb = nxt();
    setCtl(8'h70);
    u_fmsp_line_node.send({1'b0, rb, 1'b0}, 10, 32);
    model(1, 1, rb, 0, 0);
    chkRx(1);
    setCtl(8'hf0);
    for (int k = 0; k < 4; k++) begin
      rb = nxt();
      if (k == 3)
        setCtl(8'hf0);
      u_fmsp_line_node.send({1'(k == 3), 1'(k != 0), rb, 1'b0}, 11, 32);
      model(3, 1, rb, k != 0, k == 3);
      chkRx(1);
    end
    setCtl(8'h00);
    tb = nxt();
    wr(`FMSP_ADDR_SERBUF, tb);
    waitFlag(8'h02);
    chk("shift out", 11'(tb), 11'(u_fmsp_line_node.m0Got));
    chk("shift period", 11'd12, 11'(u_fmsp_line_node.m0Per));
    rb = nxt();
    u_fmsp_line_node.m0Tx = rb;
    u_fmsp_line_node.m0Idx = 0;
    u_fmsp_line_node.m0Rx = 1'b1;
    // filter bit set on purpose, no effect in mode 0
    setCtl(8'h30);
    waitFlag(8'h01);
    model(0, 1, rb, 0, 0);
    chkRx(0);
    setCtl(8'h00);
    u_fmsp_line_node.m0Rx = 1'b0;
    conclude();
  end

  initial begin
    #(20000 * 50);
    miscompares++;
    conclude();
  end
endmodule
